// ### dcsc_chain_model.sv
// behavioural far side: a driver chain that shifts in serial data
// assumes the bench hands over the current clock inversion setting
`timescale 1ns/10ps
module dcsc_chain_model (
    input wire logic clk,
    input wire logic chain_clock,
    input wire logic chain_data,
    input wire logic clk_inv,
    output logic [35:0] shifted,
    output logic [8:0] period
);
    // ============================================================
    // capture
    logic prev_r = 1'b0; // last true clock level
    logic [8:0] cnt_r = 9'h000; // cycles since last rising edge
    // shift on the true rising edge, so inversion is undone here
    always_ff @(posedge clk) begin
        prev_r <= chain_clock ^ clk_inv;
        cnt_r <= cnt_r + 9'h001;
        if ((chain_clock ^ clk_inv) && !prev_r) begin
            shifted <= {shifted[34:0], chain_data};
            period <= cnt_r;
            cnt_r <= 9'h001;
        end
    end
endmodule : dcsc_chain_model

// ### dcsc_params.svh
// constants of the driver chain serial port: offsets, fields, resets, timing
// assumes a 32-bit AXI4-Lite register bus and a single system clock
`ifndef DCSC_PARAMS_SVH
`define DCSC_PARAMS_SVH

// ============================================================
// register byte offsets
`define DCSC_CFG_OFS 8'h00
`define DCSC_DG_OFS 8'h04
`define DCSC_CTRL_OFS 8'h10

// ============================================================
// field positions and reset values
`define DCSC_START_BIT 0
`define DCSC_BUSY_BIT 0
`define DCSC_CFG_RST 17'h10F00
`define DCSC_DIV_RST 8'h0F

// ============================================================
// datagram bit masks touched by each polarity bit
`define DCSC_PH_MASK 12'h210
`define DCSC_FD_MASK 12'h400
`define DCSC_DAC_MASK 12'h1EF

// ============================================================
// timing
`define DCSC_MIN_DIV 8'h07
`define DCSC_FAST_PER 9'h010
`define DCSC_RESP_OK 2'b00
`define DCSC_RESP_ERR 2'b10

`endif

// ### dcsc_pkg.sv
// types shared by the driver chain serial port files
// assumes dcsc_params.svh is compiled alongside
package dcsc_pkg;

    // ============================================================
    // configuration word, msb first, as it sits in the cfg register
    typedef struct packed {
        logic serial_enable;             // serial drivers in use
        logic [7:0] chain_clock_divider; // serial clock divider
        logic select_mode_bit;           // 1: three single selects
        logic current_level_invert;      // invert current bits
        logic fast_decay_invert;         // fast decay active low
        logic phase_bit_invert;          // invert phase bits
        logic clock_invert;              // invert serial clock
        logic select_invert;             // common select active high
        logic [1:0] chain_length_setting; // last driver index
    } dcsc_cfg_t;

    // ============================================================
    // frame sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LEAD = 5'b00010,
        ST_DATA = 5'b00100,
        ST_GAP = 5'b01000,
        ST_TRAIL = 5'b10000
    } dcsc_state_t;

endpackage : dcsc_pkg

// ### dcsc_regs.sv
// axi4-lite register file of the driver chain serial port
// assumes one master, one write and one read outstanding at most
`timescale 1ns/10ps
`include "dcsc_params.svh"
module dcsc_regs
    import dcsc_pkg::*;
#(
    parameter int DG_W = 12,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output dcsc_cfg_t cfg,
    output logic [2:0][DG_W-1:0] dg,
    output logic start,
    input wire logic busy
);
    localparam int CW = $bits(dcsc_cfg_t);

    logic aw_ok_r; // write address held
    logic [AW-1:0] aw_a_r;
    logic w_ok_r; // write data held
    logic [31:0] w_d_r;
    logic [3:0] w_s_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [CW-1:0] cfg_r;
    logic [2:0][DG_W-1:0] dg_r;
    logic start_r;
    logic wr_go; // both halves of a write present
    logic [31:0] bmask; // byte lanes as bit mask
    logic [2:0] dg_hit;

    // ============================================================
    // handshakes: one write and one read in flight
    assign awready = !aw_ok_r && !bvalid_r;
    assign wready = !w_ok_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign wr_go = aw_ok_r && w_ok_r && !bvalid_r;
    assign bmask = {{8{w_s_r[3]}}, {8{w_s_r[2]}}, {8{w_s_r[1]}}, {8{w_s_r[0]}}};
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign cfg = dcsc_cfg_t'(cfg_r);
    assign dg = dg_r;
    assign start = start_r;

    // merge new bytes over the old word
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~bmask) | (w_d_r & bmask);
    endfunction : merge

    // address and data are taken in either order
    always_ff @(posedge clk) begin
        if (rst || wr_go) begin
            aw_ok_r <= 1'b0;
        end else if (awvalid && awready) begin
            aw_ok_r <= 1'b1;
        end
        if (awvalid && awready) begin
            aw_a_r <= awaddr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || wr_go) begin
            w_ok_r <= 1'b0;
        end else if (wvalid && wready) begin
            w_ok_r <= 1'b1;
        end
        if (wvalid && wready) begin
            w_d_r <= wdata;
            w_s_r <= wstrb;
        end
    end

    // ============================================================
    // write response; unmapped offsets answer slverr
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= `DCSC_RESP_OK;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_a_r == AW'(`DCSC_CFG_OFS) || aw_a_r == AW'(`DCSC_CTRL_OFS)
                        || dg_hit != 3'b000) ? `DCSC_RESP_OK : `DCSC_RESP_ERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // configuration word; divider resets to 15, serial mode on
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= `DCSC_CFG_RST;
        end else if (wr_go && aw_a_r == AW'(`DCSC_CFG_OFS)) begin
            cfg_r <= CW'(merge(32'(cfg_r)));
        end
    end

    // datagram words, one per driver
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_dg
            assign dg_hit[gi] = (aw_a_r == AW'(`DCSC_DG_OFS + 4 * gi));
            always_ff @(posedge clk) begin
                if (rst) begin
                    dg_r[gi] <= '0;
                end else if (wr_go && dg_hit[gi]) begin
                    dg_r[gi] <= DG_W'(merge(32'(dg_r[gi])));
                end
            end
        end
    endgenerate

    // start is a one-cycle pulse; ignored by the sequencer while busy
    always_ff @(posedge clk) begin
        if (rst) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr_go && aw_a_r == AW'(`DCSC_CTRL_OFS) && w_s_r[0]
                       && w_d_r[`DCSC_START_BIT];
        end
    end

    // ============================================================
    // read channel; unused bits read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `DCSC_RESP_OK;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= `DCSC_RESP_OK;
            rdata_r <= 32'h0000_0000;
            if (araddr == AW'(`DCSC_CFG_OFS)) begin
                rdata_r <= 32'(cfg_r);
            end else if (araddr == AW'(`DCSC_CTRL_OFS)) begin
                rdata_r[`DCSC_BUSY_BIT] <= busy;
            end else if (araddr == AW'(`DCSC_DG_OFS)) begin
                rdata_r <= 32'(dg_r[0]);
            end else if (araddr == AW'(`DCSC_DG_OFS + 8'h04)) begin
                rdata_r <= 32'(dg_r[1]);
            end else if (araddr == AW'(`DCSC_DG_OFS + 8'h08)) begin
                rdata_r <= 32'(dg_r[2]);
            end else begin
                rresp_r <= `DCSC_RESP_ERR;
            end
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : dcsc_regs

// ### dcsc_top.sv
// driver chain serial master: frames datagrams to up to three drivers
// assumes a 200 MHz clk, synchronous active-high rst, axi4-lite master
//
// Operation
// - polarity group acts only in serial mode (here clock and common select polarity set the idle pins with it off too)
// - common select low-active at 0, high-active 1
// - serial clock inverted when clock bit set
// - phase bits inverted when phase bit set
// - fast decay low-active when its bit set
// - current level bits inverted when bit set
// - select mode: one common or three selects
// - individual selects always active low
// - eight-bit divider resets to fifteen
// - serial clock is clk over 2(div+1)
// - below seven: same rate, asymmetric duty
// - next-motor gap: 1 or 1.5 periods (below seven here: two low halves)
// - lead period, bits plus one each, trail (below seven here lead and trail are two low halves each)
// - chain length 00/01/10 gives 1/2/3 drivers
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "dcsc_params.svh"
module dcsc_top
    import dcsc_pkg::*;
#(
    parameter int DG_W = 12,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic chain_clock,
    output logic chain_data,
    output logic common_select,
    output logic second_driver_select,
    output logic third_driver_select
);
    localparam int BW = $clog2(DG_W);
    localparam logic [BW-1:0] LAST_BIT = BW'(DG_W - 1);

    dcsc_cfg_t cfg; // live configuration
    dcsc_cfg_t cfg_l_r; // configuration frozen for a frame
    logic [2:0][DG_W-1:0] dg; // datagram words from software
    logic start; // start pulse from software
    dcsc_state_t state_r;
    logic [8:0] cnt_r; // cycles left in this half period
    logic [1:0] hcnt_r; // halves spent in lead, gap or trail
    logic [BW-1:0] bcnt_r; // bit of the current datagram
    logic [1:0] drv_r; // driver now being served
    logic half_r; // second half of a bit: clock high
    logic [DG_W-1:0] sh_r; // outgoing datagram
    logic tick; // end of a half period
    logic act; // frame under way
    logic go; // frame accepted
    logic [8:0] hi_l; // high half length, frozen
    logic [8:0] lo_l; // low half length, frozen
    logic [1:0] gap_last; // last half index of a gap
    logic [1:0] last_drv; // index of the first driver sent
    logic sck_r;
    logic sdo_r;
    logic cs0_r;
    logic cs1_r;
    logic cs2_r;

    // ============================================================
    // register file
    dcsc_regs #(
        .DG_W(DG_W),
        .AW(AW)
    ) u_regs (
        .clk(clk),
        .rst(rst),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .cfg(cfg),
        .dg(dg),
        .start(start),
        .busy(act)
    );

    // ============================================================
    // clock timing helpers
    // high half is div+1 cycles; below seven the period stays sixteen
    function automatic logic [8:0] hi_of(input logic [7:0] d);
        hi_of = {1'b0, d} + 9'h001;
    endfunction : hi_of

    function automatic logic [8:0] lo_of(input logic [7:0] d);
        lo_of = (d < `DCSC_MIN_DIV) ? `DCSC_FAST_PER - hi_of(d) : hi_of(d);
    endfunction : lo_of

    // code 11 is a host fault; treat it as three drivers rather than hang
    function automatic logic [1:0] len_of(input logic [1:0] l);
        len_of = (l == 2'b11) ? 2'b10 : l;
    endfunction : len_of

    // polarity masks applied only when the word is loaded for shifting
    function automatic logic [DG_W-1:0] word_of(input logic [1:0] i);
        logic [DG_W-1:0] m;
        m = '0;
        if (cfg_l_r.phase_bit_invert) begin
            m = m | DG_W'(`DCSC_PH_MASK);
        end
        if (cfg_l_r.fast_decay_invert) begin
            m = m | DG_W'(`DCSC_FD_MASK);
        end
        if (cfg_l_r.current_level_invert) begin
            m = m | DG_W'(`DCSC_DAC_MASK);
        end
        word_of = dg[i] ^ m;
    endfunction : word_of

    assign hi_l = hi_of(cfg_l_r.chain_clock_divider);
    assign lo_l = lo_of(cfg_l_r.chain_clock_divider);
    // a gap of three halves is 1.5 periods, two halves one period at divider seven; below seven it is two low halves
    assign gap_last = (cfg_l_r.chain_clock_divider > `DCSC_MIN_DIV) ? 2'd2 : 2'd1;
    assign last_drv = len_of(cfg_l_r.chain_length_setting);
    assign tick = (cnt_r == 9'h000);
    assign act = (state_r != ST_IDLE);
    // serial mode gate: no frame otherwise; clock and select polarity still set the idle pins
    assign go = (state_r == ST_IDLE) && start && cfg.serial_enable;

    // ============================================================
    // config follows software while idle, frozen during a frame
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_l_r <= dcsc_cfg_t'(`DCSC_CFG_RST);
        end else if (state_r == ST_IDLE) begin
            cfg_l_r <= cfg;
        end
    end

    // half period timer; next length depends on which half follows
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 9'h000;
        end else if (state_r == ST_IDLE) begin
            cnt_r <= lo_of(cfg.chain_clock_divider) - 9'h001;
        end else if (tick) begin
            cnt_r <= ((state_r == ST_DATA && !half_r) ? hi_l : lo_l) - 9'h001;
        end else begin
            cnt_r <= cnt_r - 9'h001;
        end
    end

    // ============================================================
    // frame sequencer: lead, per driver bits and gap, trail
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            hcnt_r <= 2'd0;
            bcnt_r <= '0;
            drv_r <= 2'd0;
            half_r <= 1'b0;
            sh_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (go) begin
                        // farthest driver's word goes first
                        state_r <= ST_LEAD;
                        hcnt_r <= 2'd0;
                        drv_r <= len_of(cfg.chain_length_setting);
                    end
                end
                ST_LEAD: begin
                    if (tick) begin
                        hcnt_r <= hcnt_r + 2'd1;
                        if (hcnt_r == 2'd1) begin
                            state_r <= ST_DATA; // two low halves done, one full period from divider seven up
                            bcnt_r <= '0;
                            half_r <= 1'b0;
                            sh_r <= word_of(drv_r);
                        end
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        half_r <= !half_r;
                        if (half_r) begin
                            if (bcnt_r == LAST_BIT) begin
                                state_r <= ST_GAP; // next-motor slot
                                hcnt_r <= 2'd0;
                            end else begin
                                bcnt_r <= bcnt_r + 1'b1;
                                sh_r <= {sh_r[DG_W-2:0], 1'b0};
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        hcnt_r <= hcnt_r + 2'd1;
                        if (hcnt_r == gap_last) begin
                            hcnt_r <= 2'd0;
                            if (drv_r == 2'd0) begin
                                state_r <= ST_TRAIL;
                            end else begin
                                state_r <= ST_DATA;
                                drv_r <= drv_r - 2'd1;
                                bcnt_r <= '0;
                                half_r <= 1'b0;
                                sh_r <= word_of(drv_r - 2'd1);
                            end
                        end
                    end
                end
                ST_TRAIL: begin
                    if (tick) begin
                        hcnt_r <= hcnt_r + 2'd1;
                        if (hcnt_r == 2'd1) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ============================================================
    // pin registers; every pin moves in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_r <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            sck_r <= ((state_r == ST_DATA) && half_r) ^ cfg_l_r.clock_invert;
            sdo_r <= (state_r == ST_DATA) ? sh_r[DG_W-1] : 1'b0;
        end
    end

    // selects: held for the frame (common) or the driver's slot
    always_ff @(posedge clk) begin
        if (rst) begin
            cs0_r <= 1'b1;
            cs1_r <= 1'b1;
            cs2_r <= 1'b1;
        end else if (cfg_l_r.select_mode_bit) begin
            // individual lines ignore the polarity bit
            cs0_r <= !(act && drv_r == 2'd0);
            cs1_r <= !(act && drv_r == 2'd1);
            cs2_r <= !(act && drv_r == 2'd2);
        end else begin
            // one shared line, polarity from software
            cs0_r <= cfg_l_r.select_invert ? act : !act;
            cs1_r <= 1'b1;
            cs2_r <= 1'b1;
        end
    end

    assign chain_clock = sck_r;
    assign chain_data = sdo_r;
    assign common_select = cs0_r;
    assign second_driver_select = cs1_r;
    assign third_driver_select = cs2_r;

    // ============================================================
    // checks: helper counters for half lengths, gaps and clock pulses
    logic sck_i; // internal clock before inversion
    logic [8:0] hc_r; // cycles clock high
    logic [8:0] lc_r; // cycles clock low inside data
    logic [8:0] gc_r; // cycles in a gap
    logic [5:0] rc_r; // rising clock edges in a frame
    assign sck_i = (state_r == ST_DATA) && half_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            hc_r <= 9'h000;
            lc_r <= 9'h000;
            gc_r <= 9'h000;
            rc_r <= 6'h00;
        end else begin
            hc_r <= sck_i ? hc_r + 9'h001 : 9'h000;
            lc_r <= (state_r == ST_DATA && !half_r) ? lc_r + 9'h001 : 9'h000;
            gc_r <= (state_r == ST_GAP) ? gc_r + 9'h001 : 9'h000;
            if (!act) begin
                rc_r <= 6'h00;
            end else if (sck_i && hc_r == 9'h000) begin
                rc_r <= rc_r + 6'h01;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_go_fast;
        go && cfg.chain_clock_divider == `DCSC_MIN_DIV;
    endsequence

    sequence s_lead16;
        (state_r == ST_LEAD) [*8] ##1 (state_r == ST_LEAD) [*8];
    endsequence

    AST_NO_FRAME_OFF: assert property (!cfg.serial_enable && !act |=> !act)
        else $error("frame started with serial mode off");
    AST_COMMON_SEL: assert property ($rose(act) && !cfg_l_r.select_mode_bit
        |=> common_select == cfg_l_r.select_invert)
        else $error("common select level wrong at frame start");
    AST_CLK_IDLE: assert property (!act && $past(!act) |-> chain_clock == $past(cfg_l_r.clock_invert))
        else $error("idle serial clock level wrong");
    AST_IND_IDLE: assert property (!act && cfg_l_r.select_mode_bit
        |=> common_select && second_driver_select && third_driver_select)
        else $error("individual select active outside a frame");
    AST_DIV_RESET: assert property ($past(rst) |-> cfg.chain_clock_divider == `DCSC_DIV_RST)
        else $error("divider not fifteen after reset");
    AST_HIGH_HALF: assert property ($fell(sck_i) |-> hc_r == hi_l)
        else $error("serial clock high half has wrong length");
    AST_LOW_HALF: assert property ($rose(sck_i) |-> lc_r == lo_l && hc_r + lc_r == lo_l)
        else $error("serial clock low half has wrong length");
    AST_GAP_LEN: assert property ($fell(state_r == ST_GAP) && cfg_l_r.chain_clock_divider >= `DCSC_MIN_DIV
        |-> gc_r == (cfg_l_r.chain_clock_divider > `DCSC_MIN_DIV ? 9'(3) * lo_l : 9'(2) * lo_l))
        else $error("next-motor gap has wrong length");
    AST_LEAD_FAST: assert property (s_go_fast |=> s_lead16 ##1 state_r == ST_DATA)
        else $error("leading period not one clock period");
    AST_BIT_COUNT: assert property ($fell(act)
        |-> rc_r == 6'(DG_W) * (6'(last_drv) + 6'h01))
        else $error("clock pulses per frame do not match chain length");
    AST_SEL_HOLD: assert property (act && $past(act) && !cfg_l_r.select_mode_bit
        |=> $stable(common_select))
        else $error("common select moved inside a frame");

endmodule : dcsc_top

// ### tb_top.sv
// self-checking bench for the driver chain serial port
// assumes the chain model file and the design files are compiled first
`timescale 1ns/10ps
`include "dcsc_params.svh"
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
    import dcsc_pkg::*;
    // ============================================================
    // signals
    logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, chain_clock, chain_data, common_select;
    logic second_driver_select, third_driver_select, si = 0, ck = 0, md = 0;
    logic [7:0] awaddr = 0, araddr = 0, dv;
    logic [31:0] wdata = 0, rdata, rd_d, cw;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, rd_r;
    logic [35:0] shifted, ex;
    logic [8:0] period;
    logic [11:0] dg [3];
    int n_fail = 0, total_checks = 0, sel_n = 0, stray = 0;
    always #2.5 clk = ~clk;
    dcsc_top dut_u (.*);
    dcsc_chain_model far_u (.clk(clk), .chain_clock(chain_clock), .chain_data(chain_data),
        .clk_inv(ck), .shifted(shifted), .period(period));
    // count cycles with any select active, and stray individual selects
    always @(posedge clk) begin
        if (md ? !(common_select & second_driver_select & third_driver_select)
            : common_select == si) sel_n++;
        if (!md && !(second_driver_select & third_driver_select)) stray++;
    end
    // ============================================================
    // bus tasks: every channel sampled at the rising edge, released just after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            rd_r = bresp;
        end while (!bvalid);
        // one idle edge, so bready never drops and rises in one time step
        bready <= 0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
            rd_d = rdata;
            rd_r = rresp;
        end while (!rvalid);
        rready <= 0;
        @(posedge clk);
    endtask : rd
    // ============================================================
    // expectations
    function automatic logic [11:0] enc(input logic [11:0] d);
        return d ^ (cw[4] ? `DCSC_PH_MASK : 12'h000) ^ (cw[5] ? `DCSC_FD_MASK : 12'h000)
            ^ (cw[6] ? `DCSC_DAC_MASK : 12'h000);
    endfunction : enc
    // lead and trail halves, 24 halves a driver, gap of 2 or 3 halves
    function automatic int flen(input int d, input int n);
        return (d + 1) * (4 + n * (24 + (d == 7 ? 2 : 3)));
    endfunction : flen
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // watchdog, well beyond twelve frames of the slowest divider used
    initial begin
        #400000;
        n_fail++;
        test_done();
    end
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h32683F65));
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(`DCSC_CFG_OFS);
        `CHK("cfg reset", 32'h00010F00, rd_d)
        rd(8'h14);
        `CHK("unmapped read", `DCSC_RESP_ERR, rd_r)
        wr(8'h14, 32'h0);
        `CHK("unmapped write", `DCSC_RESP_ERR, rd_r)
        for (int it = 0; it < 12; it++) begin
            // first the fastest divider, then a short one, then random
            dv = it == 0 ? `DCSC_MIN_DIV : it == 1 ? 8'h03 : 8'h08 + 8'($urandom_range(12));
            cw = $urandom;
            // corner cases: both select modes, all inversions, early on
            if (it < 4) cw[7:2] = it[0] ? 6'h1F : 6'h20;
            cw[1:0] = 2'($urandom_range(2));
            if (cw[7]) cw[2] = 1'b0;
            cw[31:8] = {15'h0, 1'b1, dv};
            md <= cw[7];
            si <= cw[2];
            ck <= cw[3];
            wr(`DCSC_CFG_OFS, cw);
            for (int i = 0; i < 3; i++) begin
                dg[i] = 12'($urandom);
                wr(8'h04 + 8'(4 * i), {20'h0, dg[i]});
            end
            sel_n = 0;
            stray = 0;
            wr(`DCSC_CTRL_OFS, 32'h1);
            rd_d = 1;
            for (int k = 0; k < 3000 && rd_d[0]; k++) rd(`DCSC_CTRL_OFS);
            ex = 0;
            for (int i = cw[1:0]; i >= 0; i--) ex = {ex[23:0], enc(dg[i])};
            `CHK("chain bits", ex, shifted & ((36'h1 << (12 * (cw[1:0] + 1))) - 1))
            `CHK("clock period", dv < 7 ? `DCSC_FAST_PER : 9'(2 * (dv + 1)), period)
            if (dv >= 7) `CHK("select cycles", flen(dv, cw[1:0] + 1), sel_n)
            `CHK("stray selects", 0, stray)
            `CHK("clock idle", ck, chain_clock)
        end
        // serial mode off: a start must not open a frame
        md <= 0;
        si <= 0;
        wr(`DCSC_CFG_OFS, 32'h00000F00);
        // select pins lag the new polarity by two edges
        repeat (2) @(posedge clk);
        sel_n = 0;
        wr(`DCSC_CTRL_OFS, 32'h1);
        repeat (40) @(posedge clk);
        `CHK("disabled frame", 0, sel_n)
        test_done();
    end
endmodule : tb_top
